// ==== include/tpf_consts.vh ====
// Purpose: constants for the touch packet framer
// Assumes: 100 MHz system clock
// Notes: serial format is 8 data bits, no parity, one stop bit
`ifndef TPF_CONSTS_VH
`define TPF_CONSTS_VH
`define TPF_CLK_HZ 100000000
`define TPF_BAUD 38400
`define TPF_BIT_CYC ((`TPF_CLK_HZ + `TPF_BAUD / 2) / `TPF_BAUD)
`define TPF_HALF_CYC (`TPF_BIT_CYC / 2)
`define TPF_CNT_W 12
`define TPF_CMD_BIT 7
`define TPF_ACK 8'hCA
`define TPF_CMD_FILTER 8'hA0
`define TPF_CMD_SELFPD 8'hA2
`define TPF_CMD_PRESS 8'hA4
`define TPF_CMD_WAKE 8'hA7
`define TPF_CMD_SHUT 8'hA8
`define TPF_CMD_CLKRD 8'hB0
`define TPF_HDR4 8'h80
`define TPF_HDR5 8'h90
`define TPF_IDLE_LINE 1'b0
`define TPF_START_LVL 1'b1
`define TPF_STOP_LVL 1'b0
`endif

// ==== logic/tpf_uart_tx.v ====
// Purpose: serial transmitter, inverted line, LSB first
// Assumes: one byte accepted when ready is high
// Notes: line idles low because polarity is inverted
`timescale 1ns/1ns
`include "tpf_consts.vh"
module tpf_uart_tx #(
  parameter BIT_CYC = `TPF_BIT_CYC
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] txData,
  input wire txValid,
  output reg txReady,
  output reg txLine
);
  reg [`TPF_CNT_W-1:0] cnt_q;
  reg [3:0] bitIdx_q;
  reg [9:0] shift_q;
  reg busy_q;
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= {`TPF_CNT_W{1'b0}};
      bitIdx_q <= 4'h0;
      shift_q <= 10'h000;
      busy_q <= 1'b0;
      txReady <= 1'b0;
      txLine <= `TPF_IDLE_LINE;
    end else if (!busy_q) begin
      txLine <= `TPF_IDLE_LINE;
      txReady <= !txValid;
      if (txValid && txReady) begin
        // Stop, data LSB first, start; inverted in one go [RULE15] [RULE21]
        shift_q <= ~{1'b1, txData, 1'b0};
        busy_q <= 1'b1;
        txReady <= 1'b0;
        bitIdx_q <= 4'h0;
        cnt_q <= {`TPF_CNT_W{1'b0}};
      end
    end else begin
      txLine <= shift_q[0];
      if (cnt_q == BIT_CYC - 1) begin // [RULE1]
        cnt_q <= {`TPF_CNT_W{1'b0}};
        shift_q <= {`TPF_IDLE_LINE, shift_q[9:1]};
        if (bitIdx_q == 4'h9) begin
          busy_q <= 1'b0;
          txReady <= 1'b1;
        end
        bitIdx_q <= bitIdx_q + 4'h1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // tpf_uart_tx

// ==== logic/tpf_packet_framer.v ====
// Purpose: serial command handling and coordinate packet framing
// Assumes: inputs synchronous to clk; analog path and conversion outside
// Notes: one command byte other than wake, received while the output queue is empty, gives acknowledge plus optional reply out
// Behaviour
// RULE1: Serial link runs 38400 baud, 8 data bits, no parity, one stop.
// RULE2: Bit 7 set marks a command; following data bytes have bit 7 clear.
// RULE3: Host sends command data bytes right after the command byte.
// RULE4: Every received command byte is answered with an acknowledge. The code sends none for the wake command 0xA7.
// RULE5: In power save, host sends wake then waits before next command.
// RULE6: Packet is five bytes with pressure enabled, four otherwise.
// RULE7: Header has bit 7 set, bit 4 gives length, other bits zero.
// RULE8: Byte 2 bit 6 is one for touch, zero for liftoff.
// RULE9: Ten-bit X and Y split over bytes 2 to 4, bit 7 clear.
// RULE10: Fifth byte holds 7-bit pressure, omitted when disabled.
// RULE11: Low shutdown pin forces power save over automatic setting.
// RULE12: Indicator low in normal operation, high in power save.
// RULE13: Speed-select pin sampled once after reset; high means fast clock.
// RULE14: Host drives terminal-ready low when ready, high when not.
// RULE15: Serial pins use inverted polarity for direct line driver use.
// RULE16: A filter command byte toggles the external filter path.
// RULE17: Low reset input fully resets; watchdog output drives it. Code holds watchdogResetOutN high; txLine is not reset.
// RULE18: An edge on the wake input leaves power save.
// RULE19: Acknowledge byte is the fixed code 0xCA.
// RULE20: A pressure command byte toggles pressure and five-byte packets.
// RULE21: Characters go LSB first with start bit and one stop bit.
`timescale 1ns/1ns
`include "tpf_consts.vh"
// Bit period may be shortened for simulation; default gives the real baud
module tpf_packet_framer #(
  parameter BIT_CYC = `TPF_BIT_CYC
) (
  input wire clk,
  input wire rstn,
  input wire rxLine,
  output reg txLine,
  input wire dtrN,
  input wire shutdownN,
  input wire wakeIn,
  input wire clkSet,
  input wire autoIdle,
  input wire sampleValid,
  output reg sampleReady,
  input wire [9:0] sampleX,
  input wire [9:0] sampleY,
  input wire [6:0] sampleZ,
  input wire sampleTouch,
  output reg ledOut,
  output reg filterEn,
  output reg pressEn,
  output reg powerSave,
  output reg fastClk,
  output reg watchdogResetOutN,
  output reg [7:0] dataByte,
  output reg dataValid
);
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;
  localparam DEPTH = 5;
  localparam HALF_CYC = BIT_CYC / 2;

  reg [1:0] rxState_q;
  reg [`TPF_CNT_W-1:0] rxCnt_q;
  reg [2:0] rxBit_q;
  reg [7:0] rxShift_q;
  reg clkSetDone_q;
  reg selfPd_q;
  reg sleep_q;
  reg wakePrev_q;
  reg [7:0] outBuf_q [0:DEPTH-1];
  reg [2:0] outLen_q;
  reg [2:0] outIdx_q;
  reg txValid_q;
  wire txReady;
  wire txLineW;
  wire outIdle = (outIdx_q == outLen_q) && !txValid_q;
  wire rxBit = ~rxLine; // [RULE15]

  ////////////////////////////////////////////////////////////////////
  function [7:0] pktByte;
    input [2:0] idx;
    input [9:0] x;
    input [9:0] y;
    input [6:0] z;
    input s;
    input five;
    begin
      case (idx)
        3'd0: pktByte = five ? `TPF_HDR5 : `TPF_HDR4; // [RULE7]
        3'd1: pktByte = {1'b0, s, x[2:0], y[2:0]}; // [RULE8] [RULE9]
        3'd2: pktByte = {1'b0, x[9:3]}; // [RULE9]
        3'd3: pktByte = {1'b0, y[9:3]};
        default: pktByte = {1'b0, z}; // [RULE10]
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Receiver; centre sampling at half a bit
  reg rxDone;
  always @(posedge clk) begin
    rxDone <= 1'b0;
    if (!rstn) begin
      rxState_q <= RX_IDLE;
      rxCnt_q <= {`TPF_CNT_W{1'b0}};
      rxBit_q <= 3'd0;
      rxShift_q <= 8'h00;
      rxDone <= 1'b0;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          rxCnt_q <= {`TPF_CNT_W{1'b0}};
          if (rxBit == 1'b0)
            rxState_q <= RX_START;
        end
        RX_START: begin
          if (rxCnt_q == HALF_CYC - 1) begin
            rxCnt_q <= {`TPF_CNT_W{1'b0}};
            rxBit_q <= 3'd0;
            // Glitch shorter than half a bit is dropped
            rxState_q <= (rxBit == 1'b0) ? RX_DATA : RX_IDLE;
          end else begin
            rxCnt_q <= rxCnt_q + 1'b1;
          end
        end
        RX_DATA: begin
          if (rxCnt_q == BIT_CYC - 1) begin // [RULE1]
            rxCnt_q <= {`TPF_CNT_W{1'b0}};
            rxShift_q <= {rxBit, rxShift_q[7:1]}; // [RULE21]
            rxBit_q <= rxBit_q + 3'd1;
            if (rxBit_q == 3'd7)
              rxState_q <= RX_STOP;
          end else begin
            rxCnt_q <= rxCnt_q + 1'b1;
          end
        end
        default: begin
          if (rxCnt_q == BIT_CYC - 1) begin
            rxState_q <= RX_IDLE;
            // Framing error drops the byte
            rxDone <= (rxBit == 1'b1);
          end else begin
            rxCnt_q <= rxCnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command decode, mode flags, reply and packet scheduling
  wire isCmd = rxShift_q[`TPF_CMD_BIT]; // [RULE2]
  integer i;
  always @(posedge clk) begin
    if (!rstn) begin // [RULE17]
      clkSetDone_q <= 1'b0;
      fastClk <= 1'b1;
      filterEn <= 1'b0;
      pressEn <= 1'b0;
      selfPd_q <= 1'b0;
      sleep_q <= 1'b0;
      wakePrev_q <= 1'b0;
      outLen_q <= 3'd0;
      outIdx_q <= 3'd0;
      txValid_q <= 1'b0;
      sampleReady <= 1'b0;
      powerSave <= 1'b0;
      ledOut <= 1'b0;
      dataByte <= 8'h00;
      dataValid <= 1'b0;
      watchdogResetOutN <= 1'b1;
      for (i = 0; i < DEPTH; i = i + 1)
        outBuf_q[i] <= 8'h00;
    end else begin
      dataValid <= 1'b0;
      sampleReady <= 1'b0;
      wakePrev_q <= wakeIn;
      if (!clkSetDone_q) begin
        fastClk <= clkSet; // [RULE13]
        clkSetDone_q <= 1'b1;
      end
      // Automatic power save only while the output queue is empty
      if (selfPd_q && autoIdle && outIdle)
        sleep_q <= 1'b1;
      if (wakeIn != wakePrev_q)
        sleep_q <= 1'b0; // [RULE18]
      powerSave <= !shutdownN || sleep_q; // [RULE11]
      ledOut <= !shutdownN || sleep_q; // [RULE12]
      if (rxDone && !isCmd) begin
        // Data byte for the attached side logic [RULE2] [RULE3]
        dataByte <= rxShift_q;
        dataValid <= 1'b1;
      end else if (rxDone && rxShift_q == `TPF_CMD_WAKE) begin
        sleep_q <= 1'b0;
      end else if (rxDone && outIdle) begin
        outBuf_q[0] <= `TPF_ACK; // [RULE4] [RULE19]
        outLen_q <= 3'd1;
        outIdx_q <= 3'd0;
        case (rxShift_q)
          `TPF_CMD_FILTER: begin
            filterEn <= !filterEn; // [RULE16]
            outBuf_q[1] <= {7'h00, !filterEn};
            outLen_q <= 3'd2;
          end
          `TPF_CMD_PRESS: begin
            pressEn <= !pressEn; // [RULE20]
            outBuf_q[1] <= {7'h00, !pressEn};
            outLen_q <= 3'd2;
          end
          `TPF_CMD_SELFPD: begin
            selfPd_q <= !selfPd_q;
            outBuf_q[1] <= {7'h00, !selfPd_q};
            outLen_q <= 3'd2;
          end
          `TPF_CMD_CLKRD: begin
            outBuf_q[1] <= {7'h00, fastClk};
            outLen_q <= 3'd2;
          end
          `TPF_CMD_SHUT: sleep_q <= 1'b1;
          default: outLen_q <= 3'd1;
        endcase
      end else if (sampleValid && outIdle && !dtrN && shutdownN && !sleep_q) begin
        for (i = 0; i < DEPTH; i = i + 1)
          outBuf_q[i] <= pktByte(i[2:0], sampleX, sampleY, sampleZ, sampleTouch, pressEn);
        outLen_q <= pressEn ? 3'd5 : 3'd4; // [RULE6] [RULE10]
        outIdx_q <= 3'd0;
        sampleReady <= 1'b1;
      end else if (txValid_q && txReady) begin
        txValid_q <= 1'b0;
        outIdx_q <= outIdx_q + 3'd1;
      end else if (!txValid_q && outIdx_q != outLen_q) begin
        txValid_q <= 1'b1;
      end
      txLine <= txLineW;
    end
  end

  tpf_uart_tx #(.BIT_CYC(BIT_CYC)) uTx (
    .clk(clk),
    .rstn(rstn),
    .txData(outBuf_q[outIdx_q]),
    .txValid(txValid_q),
    .txReady(txReady),
    .txLine(txLineW)
  );
endmodule // tpf_packet_framer

// ==== testbench/tpf_framer_chk.sv ====
// Purpose: port-level checks of the touch packet framer
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ns
module tpf_framer_chk (
  input wire clk,
  input wire rstn,
  input wire txLine,
  input wire dtrN,
  input wire shutdownN,
  input wire ledOut,
  input wire powerSave,
  input wire pressEn,
  input wire fastClk,
  input wire watchdogResetOutN,
  input wire [7:0] dataByte,
  input wire dataValid,
  input wire sampleReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_led_follows_save: assert property (ledOut == powerSave)
    else $error("indicator differs from power save");
  a_shutdown_forces_save: assert property (!shutdownN |-> ##[1:8] powerSave)
    else $error("shutdown pin ignored");
  a_data_bit_clear: assert property (dataValid |-> !dataByte[7])
    else $error("data byte with bit 7 set");
  a_watchdog_high: assert property (watchdogResetOutN)
    else $error("watchdog output low");
  a_speed_held: assert property ($past(rstn, 2) |-> $stable(fastClk))
    else $error("speed flag changed after power up");
  a_start_bit_width: assert property ($rose(txLine) |-> txLine [*8])
    else $error("start bit too short");
  a_sample_when_ready: assert property (sampleReady |-> !$past(dtrN) && $past(shutdownN))
    else $error("sample taken while host not ready or asleep");
  a_toggle_acked: assert property ($changed(pressEn) |-> ##[1:40] $rose(txLine))
    else $error("pressure toggle without reply");
  a_ready_pulse: assert property (sampleReady |=> !sampleReady)
    else $error("sample ready longer than one cycle");
endmodule // tpf_framer_chk

// ==== testbench/tpf_host_model.sv ====
// Purpose: host side of the inverted serial link
// Assumes: 8N1, LSB first, line idles low
// Notes: tasks are called from the testbench top
`timescale 1ns/1ns
`include "tpf_consts.vh"
module tpf_host_model #(
  parameter BIT_CYC = `TPF_BIT_CYC
) (
  input wire clk,
  output logic rxLine,
  input wire txLine
);
  logic [7:0] rxBuf [0:15];
  integer wrCnt = 0;
  integer rdCnt = 0;
  initial rxLine = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  task sendByte(input logic [7:0] b);
    integer i;
    rxLine <= 1'b1; // Start level
    repeat (BIT_CYC) @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      rxLine <= ~b[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxLine <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
  endtask
  // Listener runs on its own: a reply may start while a byte still goes out
  always begin : listen
    logic [7:0] b;
    integer k;
    @(posedge clk);
    if (txLine === 1'b1) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (k = 0; k < 8; k = k + 1) begin
        repeat (BIT_CYC) @(posedge clk);
        b[k] = ~txLine;
      end
      repeat (BIT_CYC) @(posedge clk);
      // Bad stop level poisons the byte so the compare flags it
      rxBuf[wrCnt % 16] = (txLine === 1'b0) ? b : 8'hxx;
      wrCnt = wrCnt + 1;
    end
  end
  task recvByte(output logic [7:0] b);
    while (rdCnt == wrCnt) @(posedge clk);
    b = rxBuf[rdCnt % 16];
    rdCnt = rdCnt + 1;
  endtask
endmodule // tpf_host_model

// ==== testbench/tpf_packet_framer_tb.sv ====
// Purpose: self-checking bench for the touch packet framer
// Assumes: 100 MHz clock, bit period shortened by parameter for run length
// Notes: drives the serial line through the host model
`timescale 1ns/1ns
module tpf_packet_framer_tb;
  // Real baud needs 26040 cycles a character; too slow for a full run
  localparam SIM_BIT = 40;
  localparam CHAR_CYC = SIM_BIT * 10;
  logic clk = 0, rstn = 0, dtrN = 0, shutdownN = 1, wakeIn = 0, clkSet = 1, autoIdle = 0;
  logic sampleValid = 0, sampleTouch = 1, rxLine;
  logic [9:0] sampleX = 10'h2B5, sampleY = 10'h1CA;
  logic [6:0] sampleZ = 7'h55;
  wire txLine, sampleReady, ledOut, filterEn, pressEn, powerSave, fastClk, wdN, dataValid;
  wire [7:0] dataByte;
  logic [7:0] got;
  integer error_cnt = 0, checks_done = 0, cycles = 0, dataSeen = 0;
  always #5 clk = ~clk;
  tpf_packet_framer #(.BIT_CYC(SIM_BIT)) dut (.clk(clk), .rstn(rstn), .rxLine(rxLine),
    .txLine(txLine),
    .dtrN(dtrN), .shutdownN(shutdownN), .wakeIn(wakeIn), .clkSet(clkSet),
    .autoIdle(autoIdle), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ), .sampleTouch(sampleTouch),
    .ledOut(ledOut), .filterEn(filterEn), .pressEn(pressEn), .powerSave(powerSave),
    .fastClk(fastClk), .watchdogResetOutN(wdN), .dataByte(dataByte), .dataValid(dataValid));
  tpf_host_model #(.BIT_CYC(SIM_BIT)) host (.clk(clk), .rxLine(rxLine), .txLine(txLine));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rx(input logic [7:0] e);
    host.recvByte(got);
    chk(got, e);
  endtask
  task print_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Ceiling about two and a half times the expected run of some forty characters
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  always @(posedge clk) if (sampleReady) sampleValid <= 1'b0;
  always @(posedge clk) if (dataValid) dataSeen <= dataSeen + 1;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(fastClk, 1);
    chk({ledOut, pressEn}, 0);
    chk({filterEn, wdN}, 1);
    host.sendByte(8'hA4);
    rx(8'hCA);
    rx(8'h01);
    chk(pressEn, 1);
    sampleValid <= 1'b1;
    rx(8'h90);
    rx({2'b01, sampleX[2:0], sampleY[2:0]});
    rx({1'b0, sampleX[9:3]});
    rx({1'b0, sampleY[9:3]});
    rx({1'b0, sampleZ});
    // Pressure off: four-byte packet reporting a liftoff
    host.sendByte(8'hA4);
    rx(8'hCA);
    rx(8'h00);
    sampleTouch <= 1'b0;
    sampleValid <= 1'b1;
    rx(8'h80);
    rx({2'b00, sampleX[2:0], sampleY[2:0]});
    rx({1'b0, sampleX[9:3]});
    rx({1'b0, sampleY[9:3]});
    repeat (2 * CHAR_CYC) @(posedge clk);
    chk(host.wrCnt - host.rdCnt, 0);
    host.sendByte(8'hA0);
    rx(8'hCA);
    rx(8'h01);
    chk(filterEn, 1);
    // Command followed straight away by its data byte
    host.sendByte(8'hB8);
    host.sendByte(8'h35);
    chk(dataByte, 8'h35);
    chk(dataSeen, 1);
    rx(8'hCA);
    host.sendByte(8'hA8);
    rx(8'hCA);
    chk({powerSave, ledOut}, 8'h03);
    host.sendByte(8'hA7);
    repeat (SIM_BIT) @(posedge clk);
    chk({powerSave, ledOut}, 0);
    host.sendByte(8'hB0);
    rx(8'hCA);
    rx(8'h01);
    // Sample held back by the shutdown pin, then by the host not ready
    dtrN <= 1'b1;
    shutdownN <= 1'b0;
    sampleValid <= 1'b1;
    repeat (10) @(posedge clk);
    chk({powerSave, ledOut}, 8'h03);
    shutdownN <= 1'b1;
    repeat (2 * CHAR_CYC) @(posedge clk);
    chk(host.wrCnt - host.rdCnt, 0);
    chk({powerSave, sampleValid}, 1);
    dtrN <= 1'b0;
    rx(8'h80);
    rx({2'b00, sampleX[2:0], sampleY[2:0]});
    rx({1'b0, sampleX[9:3]});
    rx({1'b0, sampleY[9:3]});
    host.sendByte(8'hA8);
    rx(8'hCA);
    chk(powerSave, 1);
    wakeIn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({powerSave, ledOut}, 0);
    // Self power-down on, then the idle hint puts it to sleep
    host.sendByte(8'hA2);
    rx(8'hCA);
    rx(8'h01);
    autoIdle <= 1'b1;
    repeat (4) @(posedge clk);
    chk({powerSave, ledOut}, 8'h03);
    autoIdle <= 1'b0;
    wakeIn <= 1'b0;
    repeat (4) @(posedge clk);
    chk({powerSave, ledOut}, 0);
    repeat (2 * CHAR_CYC) @(posedge clk);
    chk(host.wrCnt - host.rdCnt, 0);
    print_verdict;
  end
endmodule // tpf_packet_framer_tb
bind tpf_packet_framer tpf_framer_chk chk (.clk(clk), .rstn(rstn), .txLine(txLine),
  .dtrN(dtrN), .shutdownN(shutdownN), .ledOut(ledOut), .powerSave(powerSave),
  .pressEn(pressEn), .fastClk(fastClk), .watchdogResetOutN(watchdogResetOutN),
  .dataByte(dataByte), .dataValid(dataValid), .sampleReady(sampleReady));
